// ---- core/glef_pkg.sv ----
// Purpose: Shared constants for the gain loop error/filter/gain block
// Assumes: APB word registers, index times four gives the byte address
// Notes: Gain code 0x800 is unity; upper nibble coarse, lower byte fine
package glef_pkg;
    // Datapath widths
    localparam int DATA_IN_W = 23;
    localparam int SCALED_W = 19;
    localparam int DIFF_W = 20;
    localparam int OUT_W = 16;
    localparam int ACC_W = 52;
    localparam int TOT_W = 54;

    // Register indices (byte address = index * 4)
    localparam logic [5:0] IDX_A_CTRL = 6'h0A;
    localparam logic [5:0] IDX_A_SETP = 6'h0B;
    localparam logic [5:0] IDX_A_CLIP = 6'h0C;
    localparam logic [5:0] IDX_A_INIT = 6'h0D;
    localparam logic [5:0] IDX_A_KGAIN = 6'h0E;
    localparam logic [5:0] IDX_A_ROOT = 6'h0F;
    localparam logic [5:0] IDX_A_AVG = 6'h10;
    localparam logic [5:0] IDX_A_RATIO = 6'h11;
    localparam logic [5:0] IDX_B_CTRL = 6'h12;
    localparam logic [5:0] IDX_B_SETP = 6'h14;
    localparam logic [5:0] IDX_B_INIT = 6'h15;
    localparam logic [5:0] IDX_B_KGAIN = 6'h16;
    localparam logic [5:0] IDX_B_ROOT = 6'h17;
    localparam logic [5:0] IDX_A_GAIN_STAT = 6'h20;

    // Field positions
    localparam int CTRL_BYPASS = 0;
    localparam int CTRL_CLIP_MODE = 4;
    localparam int CTRL_WSEL_LSB = 5;
    localparam int AVG_MULT_LSB = 0;
    localparam int AVG_ATTEN_LSB = 2;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_INIT_GAIN = 12'h800;
    localparam logic [11:0] RST_RATIO = 12'h000;

    // Full-scale rms (2^18) in 1/64 octave steps
    localparam logic signed [13:0] LOG_REF = 14'h0480;
    localparam logic signed [23:0] VEL_MAX = 24'h7FFFFF;
    localparam logic signed [23:0] VEL_MIN = 24'h800000;
    localparam logic [19:0] GAIN_ACC_MAX = 20'hFFFFF;
endpackage

// ---- core/glef_gain_if.sv ----
// Purpose: Carries one rail (I or Q) between loop and scaler
// Assumes: Purely combinational path inside one clock cycle
// Notes: One instance per rail
interface glef_gain_if;
    logic signed [22:0] sample;
    logic [3:0] coarse;
    logic [7:0] fine;
    logic [2:0] width_sel;
    logic bypass;
    logic signed [18:0] scaled;
    logic signed [19:0] trunc_err;
    logic signed [15:0] port_out;

    modport loop (output sample, coarse, fine, width_sel, bypass,
                  input scaled, trunc_err, port_out);
    modport scaler (input sample, coarse, fine, width_sel, bypass,
                    output scaled, trunc_err, port_out);
endinterface

// ---- core/glef_scaler.sv ----
// Purpose: Coarse shift and fine multiply of one rail, then width clip
// Assumes: Gain code from the loop, held between updates
// Notes: Fine step is linear 1+f/256, a close stand-in for 2^(f/256)
module glef_scaler (
    // Rail carrier
    glef_gain_if.scaler g
);
    logic signed [32:0] prod;
    logic signed [32:0] shifted;
    logic [4:0] sh;
    logic [4:0] w;
    logic [19:0] one_sh;
    logic signed [18:0] lim;
    logic signed [18:0] clipped;

    always_comb begin
        // Fine multiply, then coarse shift: 16 down to 1 right shifts
        prod = 33'(g.sample * $signed({1'h0, 1'h1, g.fine}));
        sh = 5'h10 - {1'h0, g.coarse};
        shifted = prod >>> sh;
        if (shifted > 33'sh3FFFF) begin
            g.scaled = 19'sh3FFFF;
        end else if (shifted < -33'sh40000) begin
            g.scaled = -19'sh40000;
        end else begin
            g.scaled = shifted[18:0];
        end
        unique case (g.width_sel)
            3'h0: w = 5'h04;
            3'h1: w = 5'h05;
            3'h2: w = 5'h06;
            3'h3: w = 5'h07;
            3'h4: w = 5'h08;
            3'h5: w = 5'h0A;
            3'h6: w = 5'h0C;
            3'h7: w = 5'h10;
        endcase
        one_sh = 20'h1 << (w - 5'h1);
        lim = $signed(19'(one_sh - 20'h1));
        if (g.scaled > lim) begin
            clipped = lim;
        end else if (g.scaled < -lim - 19'sh1) begin
            clipped = -lim - 19'sh1;
        end else begin
            clipped = g.scaled;
        end
        // Residue the clip-level loop regulates
        g.trunc_err = 20'(g.scaled) - 20'(clipped);
        if (g.bypass) begin
            if (g.sample > 23'sh7FFF) begin
                g.port_out = 16'sh7FFF;
            end else if (g.sample < -23'sh8000) begin
                g.port_out = -16'sh8000;
            end else begin
                g.port_out = g.sample[15:0];
            end
        end else begin
            g.port_out = clipped[15:0];
        end
    end
endmodule

// ---- core/glef_gain_loop.sv ----
// Purpose: Log-linear gain loop for one I/Q pair with APB registers
// Assumes: One sample per in_valid; APB slave answers with one wait
// Notes: Datapath serves loop A; loop B registers are stored only
// Notes: Control bits: 0 bypass, 4 clip mode, 7:5 output width select
// Notes: Averaging word: 1:0 multiple less one, 5:2 power shift
// Notes: Ratio word holds samples per update less one
// Notes: Index 0x20 reads back the live gain code
// Notes on behaviour
// - Log2 of averaged power, halved by one shift to give log rms.
// - Level mode error is setpoint minus log rms, into loop filter.
// - Setpoint spans 0 to -23.99 dB, 0.094 dB per code.
// - Second-order loop filter, open-loop poles at one and root.
// - Filter gain and root are unsigned 8-bit fractions, own registers.
// - Linear gain is two raised to the loop filter output.
// - Gain is 8-bit fine multiply then 4-bit coarse shift, both rails.
// - Gain before first update comes from the initial gain register.
// - Products are 19-bit and also feed the power and error path.
// - Outputs truncated to 4,5,6,7,8,10,12 or 16 bits per control.
// - Control bit 4 set selects clipping level mode.
// - Clip mode error is difference before and after truncation.
// - Clip mode subtracts the clip level in place of the setpoint.
// - Control bit 4 clear selects signal level mode, pre-clip path.
// - Control bit 0 bypasses the loop, output clipped to 16 bits.
// - Average multiple times ratio samples; multiple in bits 1:0.
// - Power shifted right by 0 to 14 before the integrator.
module glef_gain_loop (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sample input
    input wire logic in_valid,
    input wire logic signed [22:0] in_i,
    input wire logic signed [22:0] in_q,
    // Sample output
    output logic out_valid,
    output logic signed [15:0] out_i,
    output logic signed [15:0] out_q,
    // Loop status
    output logic [11:0] gain_level,
    output logic update_pulse
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] a_ctrl;
        logic [7:0] a_setp;
        logic [7:0] a_clip;
        logic [11:0] a_init;
        logic [7:0] a_kgain;
        logic [7:0] a_root;
        logic [7:0] a_avg;
        logic [11:0] a_ratio;
        logic [7:0] b_ctrl;
        logic [7:0] b_setp;
        logic [11:0] b_init;
        logic [7:0] b_kgain;
        logic [7:0] b_root;
        logic [19:0] gain_acc;
        logic signed [23:0] vel;
        logic signed [13:0] err_prev;
        logic [11:0] cnt;
        logic [glef_pkg::ACC_W-1:0] acc;
        logic [3:0][glef_pkg::ACC_W-1:0] blk;
        logic [1:0] blk_ptr;
        logic out_valid;
        logic signed [15:0] out_i;
        logic signed [15:0] out_q;
        logic update;
    } glef_state_s;

    glef_state_s q;
    glef_state_s n;

    glef_gain_if gi ();
    glef_gain_if gq ();

    glef_scaler u_scale_i (
        .g(gi.scaler)
    );
    glef_scaler u_scale_q (
        .g(gq.scaler)
    );

    logic [5:0] idx;
    logic hit;
    logic [31:0] rd_data;
    logic clip_mode;
    logic [3:0] atten;
    logic signed [19:0] sel_i;
    logic signed [19:0] sel_q;
    logic [40:0] pw;
    logic [40:0] pwa;
    logic [glef_pkg::ACC_W-1:0] acc_next;
    logic [glef_pkg::TOT_W-1:0] total;
    logic [glef_pkg::TOT_W-1:0] norm;
    logic [5:0] msb;
    logic [10:0] amp;
    logic [7:0] ref_lvl;
    logic signed [13:0] err_now;
    logic signed [32:0] vel_mul;
    logic signed [25:0] kerr;
    logic signed [25:0] vel_sum;
    logic signed [24:0] gain_sum;
    logic [1:0] bi;

    assign idx = paddr[7:2];
    assign clip_mode = q.a_ctrl[glef_pkg::CTRL_CLIP_MODE];
    // A shift code of 15 is out of range; hold it at the top step
    always_comb begin
        atten = q.a_avg[glef_pkg::AVG_ATTEN_LSB +: 4];
        if (atten > 4'hE) begin
            atten = 4'hE;
        end
    end

    // Rail drive: gain code splits into coarse nibble and fine byte
    assign gi.sample = in_i;
    assign gq.sample = in_q;
    assign gi.coarse = q.gain_acc[19:16];
    assign gq.coarse = q.gain_acc[19:16];
    assign gi.fine = q.gain_acc[15:8];
    assign gq.fine = q.gain_acc[15:8];
    assign gi.width_sel = q.a_ctrl[glef_pkg::CTRL_WSEL_LSB +: 3];
    assign gq.width_sel = q.a_ctrl[glef_pkg::CTRL_WSEL_LSB +: 3];
    assign gi.bypass = q.a_ctrl[glef_pkg::CTRL_BYPASS];
    assign gq.bypass = q.a_ctrl[glef_pkg::CTRL_BYPASS];

    // Register read decode
    always_comb begin
        hit = (paddr[1:0] == 2'h0);
        rd_data = 32'h0;
        unique case (idx)
            glef_pkg::IDX_A_CTRL: rd_data = {24'h0, q.a_ctrl};
            glef_pkg::IDX_A_SETP: rd_data = {24'h0, q.a_setp};
            glef_pkg::IDX_A_CLIP: rd_data = {24'h0, q.a_clip};
            glef_pkg::IDX_A_INIT: rd_data = {20'h0, q.a_init};
            glef_pkg::IDX_A_KGAIN: rd_data = {24'h0, q.a_kgain};
            glef_pkg::IDX_A_ROOT: rd_data = {24'h0, q.a_root};
            glef_pkg::IDX_A_AVG: rd_data = {24'h0, q.a_avg};
            glef_pkg::IDX_A_RATIO: rd_data = {20'h0, q.a_ratio};
            glef_pkg::IDX_B_CTRL: rd_data = {24'h0, q.b_ctrl};
            glef_pkg::IDX_B_SETP: rd_data = {24'h0, q.b_setp};
            glef_pkg::IDX_B_INIT: rd_data = {20'h0, q.b_init};
            glef_pkg::IDX_B_KGAIN: rd_data = {24'h0, q.b_kgain};
            glef_pkg::IDX_B_ROOT: rd_data = {24'h0, q.b_root};
            glef_pkg::IDX_A_GAIN_STAT: rd_data = {20'h0, q.gain_acc[19:8]};
            default: hit = 1'h0;
        endcase
    end

    always_comb begin
        n = q;
        n.pready = 1'h0;
        n.pslverr = 1'h0;
        n.update = 1'h0;
        n.out_valid = 1'h0;
        sel_i = 20'sh0;
        sel_q = 20'sh0;
        pw = 41'h0;
        pwa = 41'h0;
        acc_next = q.acc;
        total = '0;
        norm = '0;
        msb = 6'h0;
        amp = 11'h0;
        ref_lvl = 8'h0;
        err_now = 14'sh0;
        vel_mul = 33'sh0;
        kerr = 26'sh0;
        vel_sum = 26'sh0;
        gain_sum = 25'sh0;
        bi = 2'h0;

        // APB: answer latched in the first access cycle, one wait state
        if (psel && penable && !q.pready) begin
            n.pready = 1'h1;
            n.prdata = pwrite ? 32'h0 : (hit ? rd_data : 32'h0);
            n.pslverr = !hit;
        end

        // Sample path
        if (in_valid) begin
            n.out_valid = 1'h1;
            n.out_i = gi.port_out;
            n.out_q = gq.port_out;
        end
        if (in_valid && !q.a_ctrl[glef_pkg::CTRL_BYPASS]) begin
            if (clip_mode) begin
                sel_i = gi.trunc_err;
                sel_q = gq.trunc_err;
            end else begin
                sel_i = 20'(gi.scaled);
                sel_q = 20'(gq.scaled);
            end
            pw = 41'(sel_i * sel_i) + 41'(sel_q * sel_q);
            // Coarse scaling keeps the integrator from wrapping
            pwa = pw >> atten;
            acc_next = q.acc + glef_pkg::ACC_W'(pwa);
            if (q.cnt == q.a_ratio) begin
                n.blk[q.blk_ptr] = acc_next;
                total = glef_pkg::TOT_W'(acc_next);
                for (int k = 1; k < 4; k++) begin
                    bi = q.blk_ptr - 2'(k);
                    if (k <= int'(q.a_avg[glef_pkg::AVG_MULT_LSB +: 2])) begin
                        total = total + glef_pkg::TOT_W'(q.blk[bi]);
                    end
                end
                n.blk_ptr = q.blk_ptr + 2'h1;
                n.acc = '0;
                n.cnt = 12'h0;
                for (int j = 0; j < glef_pkg::TOT_W; j++) begin
                    if (total[j]) begin
                        msb = 6'(j);
                    end
                end
                // Six fraction bits from the bits below the leading one
                norm = total << (6'(glef_pkg::TOT_W - 1) - msb);
                if (total != '0) begin
                    amp = 11'({msb, norm[glef_pkg::TOT_W-2 -: 6]}
                        >> 1);
                end
                ref_lvl = clip_mode ? q.a_clip : q.a_setp;
                err_now = glef_pkg::LOG_REF - $signed({6'h0, ref_lvl})
                    - $signed({3'h0, amp});
                // v[n] = P*v[n-1] + K*e[n-1]; gain integrates v
                vel_mul = 33'($signed({1'h0, q.a_root}) * q.vel);
                kerr = 26'($signed({1'h0, q.a_kgain}) * q.err_prev);
                vel_sum = 26'(vel_mul >>> 8) + (kerr <<< 2);
                if (vel_sum > 26'(glef_pkg::VEL_MAX)) begin
                    n.vel = glef_pkg::VEL_MAX;
                end else if (vel_sum < 26'(glef_pkg::VEL_MIN)) begin
                    n.vel = glef_pkg::VEL_MIN;
                end else begin
                    n.vel = vel_sum[23:0];
                end
                // Log-domain gain; scaler turns it into 2^x
                gain_sum = $signed({5'h0, q.gain_acc}) + 25'(n.vel);
                if (gain_sum < 25'sh0) begin
                    n.gain_acc = 20'h0;
                end else if (gain_sum > $signed({5'h0,
                        glef_pkg::GAIN_ACC_MAX})) begin
                    n.gain_acc = glef_pkg::GAIN_ACC_MAX;
                end else begin
                    n.gain_acc = gain_sum[19:0];
                end
                n.err_prev = err_now;
                n.update = 1'h1;
            end else begin
                n.cnt = q.cnt + 12'h1;
                n.acc = acc_next;
            end
        end

        // Register writes land on the edge where the master sees pready
        if (psel && penable && q.pready && pwrite && hit) begin
            unique case (idx)
                glef_pkg::IDX_A_CTRL: n.a_ctrl = pwdata[7:0];
                glef_pkg::IDX_A_SETP: n.a_setp = pwdata[7:0];
                glef_pkg::IDX_A_CLIP: n.a_clip = pwdata[7:0];
                glef_pkg::IDX_A_INIT: begin
                    n.a_init = pwdata[11:0];
                    n.gain_acc = {pwdata[11:0], 8'h00};
                    n.vel = 24'sh0;
                    n.err_prev = 14'sh0;
                end
                glef_pkg::IDX_A_KGAIN: n.a_kgain = pwdata[7:0];
                glef_pkg::IDX_A_ROOT: n.a_root = pwdata[7:0];
                glef_pkg::IDX_A_AVG: n.a_avg = pwdata[7:0];
                glef_pkg::IDX_A_RATIO: begin
                    n.a_ratio = pwdata[11:0];
                    n.cnt = 12'h0;
                    n.acc = '0;
                end
                glef_pkg::IDX_B_CTRL: n.b_ctrl = pwdata[7:0];
                glef_pkg::IDX_B_SETP: n.b_setp = pwdata[7:0];
                glef_pkg::IDX_B_INIT: n.b_init = pwdata[11:0];
                glef_pkg::IDX_B_KGAIN: n.b_kgain = pwdata[7:0];
                glef_pkg::IDX_B_ROOT: n.b_root = pwdata[7:0];
                default: n.a_ctrl = q.a_ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.a_init <= glef_pkg::RST_INIT_GAIN;
            q.b_init <= glef_pkg::RST_INIT_GAIN;
            q.gain_acc <= {glef_pkg::RST_INIT_GAIN, 8'h00};
            q.a_ratio <= glef_pkg::RST_RATIO;
            q.a_ctrl <= glef_pkg::RST_BYTE;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign out_valid = q.out_valid;
    assign out_i = q.out_i;
    assign out_q = q.out_q;
    assign gain_level = q.gain_acc[19:8];
    assign update_pulse = q.update;
endmodule

// ---- verif/glef_gain_loop_sva.sv ----
// Purpose: Port-level assertions for the gain loop block
// Assumes: Control A and initial gain tracked from APB writes
// Notes: Bound into glef_gain_loop after the module
module glef_gain_loop_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Samples
    input wire logic in_valid,
    input wire logic signed [22:0] in_i,
    input wire logic signed [22:0] in_q,
    input wire logic out_valid,
    input wire logic signed [15:0] out_i,
    input wire logic signed [15:0] out_q,
    // Status
    input wire logic [11:0] gain_level,
    input wire logic update_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] ctrl_q;
    logic [11:0] init_q;
    logic wr, wri, mapped, fit;
    logic signed [15:0] hi;
    int wbits;

    function automatic logic signed [15:0] sat(logic signed [22:0] x);
        if (x > 23'sh007FFF) return 16'sh7FFF;
        if (x < 23'sh7F8000) return 16'sh8000;
        return x[15:0];
    endfunction

    always_comb begin
        wr = psel && penable && pready && pwrite;
        wri = wr && paddr == {glef_pkg::IDX_A_INIT, 2'h0};
        mapped = paddr[7:2] inside {[6'h0A:6'h12], [6'h14:6'h17], 6'h20};
        case (ctrl_q[7:5])
            3'h5: wbits = 10;
            3'h6: wbits = 12;
            3'h7: wbits = 16;
            default: wbits = 4 + int'(ctrl_q[7:5]);
        endcase
        hi = out_i >>> (wbits - 1);
        fit = (hi == 16'sh0000) || (hi == 16'shFFFF);
    end

    // Shadow copies, so checks need no view inside the block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
            init_q <= 12'h800;
        end else if (wr && paddr == {glef_pkg::IDX_A_CTRL, 2'h0}) begin
            ctrl_q <= pwdata[7:0];
        end else if (wri) begin
            init_q <= pwdata[11:0];
        end
    end

    AST_READY_WAIT: assert property (
        $rose(psel && penable) |-> !pready ##1 pready)
        else $error("pready not after one wait");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_BAD: assert property (
        pready && (paddr[1:0] != 2'h0 || !mapped) |-> pslverr)
        else $error("bad address not refused");
    AST_ERR_ONLY: assert property (
        pslverr |-> pready && (paddr[1:0] != 2'h0 || !mapped))
        else $error("pslverr without cause");
    AST_OUT_HOLD: assert property (
        !in_valid |=> !out_valid && $stable(out_i) && $stable(out_q))
        else $error("output moved without sample");
    AST_OUT_LAT: assert property (in_valid |=> out_valid)
        else $error("out_valid not one cycle after sample");
    AST_BYPASS_SAT: assert property (
        ctrl_q[0] && in_valid |=>
        out_i == sat($past(in_i)) && out_q == sat($past(in_q)))
        else $error("bypass output not saturated input");
    AST_BYPASS_FROZEN: assert property (
        $past(ctrl_q[0]) |-> !update_pulse)
        else $error("loop updated in bypass");
    AST_WIDTH: assert property (
        out_valid && !ctrl_q[0] && $stable(ctrl_q) |-> fit)
        else $error("output exceeds selected width");
    AST_UPD_CAUSE: assert property (
        update_pulse |-> $past(in_valid))
        else $error("update without sample");
    AST_GAIN_HOLD: assert property (
        !$stable(gain_level) |->
        update_pulse || $past(wri) || $past(wri, 2))
        else $error("gain moved between updates");
    AST_INIT_LOAD: assert property (
        wri |-> ##[1:2] gain_level == init_q)
        else $error("initial gain not loaded");
endmodule

bind glef_gain_loop glef_gain_loop_chk i_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_i, .in_q, .out_valid, .out_i, .out_q, .gain_level,
    .update_pulse);

// ---- verif/glef_rake_sink.sv ----
// Purpose: Stands in for the receiver fed by the scaled samples
// Assumes: Takes a pair on every edge where out_valid is high
// Notes: Never stalls; the block has no backpressure
module glef_rake_sink (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Scaled samples
    input wire logic out_valid,
    input wire logic signed [15:0] out_i,
    input wire logic signed [15:0] out_q,
    // Bench view
    output logic signed [15:0] last_i,
    output int taken
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken <= 0;
            last_i <= 16'sh0000;
        end else if (out_valid) begin
            taken <= taken + 1;
            last_i <= out_i;
        end
    end
endmodule

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the gain loop block
// Assumes: APB slave with one wait state, one-cycle sample latency
// Notes: Register byte address is index times four
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, wv;
    logic pready, pslverr, in_valid, out_valid, update_pulse;
    logic signed [22:0] in_i, in_q, x;
    logic signed [15:0] out_i, out_q, last_i;
    logic [11:0] gain_level, g0;
    int miscompares = 0, check_count = 0, taken, sent = 0, upd;
    logic [5:0] ridx [13] = '{6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
        6'h10, 6'h11, 6'h12, 6'h14, 6'h15, 6'h16, 6'h17};
    logic [11:0] rmask [13] = '{12'h0FF, 12'h0FF, 12'h0FF, 12'hFFF,
        12'h0FF, 12'h0FF, 12'h0FF, 12'hFFF, 12'h0FF, 12'h0FF, 12'hFFF,
        12'h0FF, 12'h0FF};
    logic signed [22:0] corner [6] = '{23'sh007FFF, 23'sh008000,
        23'sh7F8000, 23'sh7F7FFF, 23'sh3FFFFF, 23'sh400000};
    int widths [8] = '{4, 5, 6, 7, 8, 10, 12, 16};

    glef_gain_loop i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_i,
        .in_q, .out_valid, .out_i, .out_q, .gain_level, .update_pulse);
    glef_rake_sink i_sink (.pclk, .presetn, .out_valid, .out_i, .out_q,
        .last_i, .taken);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    function automatic logic signed [15:0] sat16(logic signed [22:0] v);
        if (v > 23'sh007FFF) return 16'sh7FFF;
        if (v < 23'sh7F8000) return 16'sh8000;
        return v[15:0];
    endfunction

    function automatic logic fits(logic signed [15:0] v, int b);
        logic signed [15:0] h;
        h = v >>> (b - 1);
        return h == 16'sh0000 || h == 16'shFFFF;
    endfunction

    task automatic apb(input logic w, input logic [5:0] idx,
                       input logic [1:0] lo, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, lo};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so the next setup never reassigns psel in this step
        @(posedge pclk);
        chk(n, 2);
    endtask

    task automatic wreg(input logic [5:0] idx, input logic [31:0] d);
        apb(1'b1, idx, 2'h0, d);
    endtask

    // Stream held valid; outputs then stand until the next sample
    task automatic burst(input int cnt, input logic signed [22:0] a);
        in_valid <= 1'b1;
        for (int k = 0; k < cnt; k++) begin
            in_i <= a;
            in_q <= -a;
            sent++;
            @(posedge pclk);
        end
        in_valid <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        finish_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, in_valid} = 5'h00;
        {paddr, pwdata, in_i, in_q} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wv = $urandom(48);
        for (int k = 0; k < 13; k++) begin
            apb(1'b0, ridx[k], 2'h0, 32'h0);
            chk(rd, rmask[k] == 12'hFFF && k != 7 ? 32'h800 : 32'h0);
        end
        apb(1'b0, 6'h20, 2'h0, 32'h0);
        chk(rd, 32'h800);
        apb(1'b0, 6'h13, 2'h0, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 6'h0A, 2'h1, 32'h1);
        chk(err, 1'b1);
        for (int k = 0; k < 13; k++) begin
            wv = $urandom();
            wreg(ridx[k], wv);
            apb(1'b0, ridx[k], 2'h0, 32'h0);
            chk(rd, wv & rmask[k]);
        end
        wv = $urandom();
        wreg(6'h0D, wv);
        repeat (3) @(posedge pclk);
        chk(gain_level, wv[11:0]);
        wreg(6'h0A, 32'h01);
        g0 = gain_level;
        for (int k = 0; k < 24; k++) begin
            x = k < 6 ? corner[k] : 23'($urandom());
            burst(1, x);
            chk(out_i, sat16(x));
            chk(out_q, sat16(-x));
        end
        chk(gain_level, g0);
        chk(last_i, sat16(x));
        wreg(6'h0E, 32'h0);
        wreg(6'h0D, 32'h800);
        for (int w = 0; w < 8; w++) begin
            wreg(6'h0A, w << 5);
            for (int k = 0; k < 4; k++) begin
                burst(1, 23'($urandom()));
                chk(fits(out_i, widths[w]), 1'b1);
            end
        end
        wreg(6'h10, 32'h0);
        wreg(6'h11, 32'h3);
        wreg(6'h0E, 32'hFF);
        upd = 0;
        for (int k = 0; k < 18; k++) begin
            in_valid <= k < 16;
            in_i <= 23'($urandom());
            in_q <= 23'($urandom());
            sent += int'(k < 16);
            @(posedge pclk);
            upd += int'(update_pulse === 1'b1);
        end
        chk(upd, 4);
        wreg(6'h11, 32'h0);
        wreg(6'h0F, 32'h0);
        wreg(6'h0B, 32'h0);
        wreg(6'h0D, 32'h800);
        burst(12, 23'sh000010);
        chk(gain_level > 12'h800, 1'b1);
        g0 = gain_level;
        wreg(6'h0B, 32'hFF);
        burst(12, 23'sh3FFFFF);
        chk(gain_level < g0, 1'b1);
        // Level mode would pull gain down here; clip mode must raise it
        wreg(6'h0A, 32'hF0);
        wreg(6'h0C, 32'h0);
        wreg(6'h0D, 32'h800);
        burst(2, 23'sh010000);
        chk(gain_level > 12'h800, 1'b1);
        chk(taken, sent);
        finish_test();
    end
endmodule
